/* File: rtl/rf_latch_regs.svh */
/*
  Constants of the serial configuration link: latch address codes, field
  positions inside the 24-bit words, reset values, timing and host registers.
  Assumes it is included by bare name from the package and design files.
*/
`ifndef RF_LATCH_REGS_SVH
`define RF_LATCH_REGS_SVH

`define WORD_BITS       24
`define ADDR_CTRL       2'h0
`define ADDR_TXCAL      2'h1
`define ADDR_LO         2'h2
`define ADDR_RX         2'h3
`define ADDR3_TX        3'h1
`define ADDR3_CAL       3'h5

`define LO_PRESC_HI     23
`define LO_PRESC_LO     22
`define LO_PUMP_BIT     21
`define LO_FBSEL_BIT    20
`define LO_MAIN_HI      19
`define LO_MAIN_LO      7
`define LO_SWAL_HI      6
`define LO_SWAL_LO      2

`define RX_BOOST_BIT    7
`define RX_CUT_HI       6
`define RX_CUT_LO       5
`define RX_GAIN_HI      4
`define RX_GAIN_LO      2

`define CTRL_PD_HI      23
`define CTRL_PD_LO      20
`define CTRL_TP_HI      19
`define CTRL_TP_LO      18
`define CTRL_CPI_HI     17
`define CTRL_CPI_LO     15
`define TX_PHASE_HI     23
`define TX_PHASE_LO     21

`define CTRL_RESET      24'hF0_0000
`define LATCH_RESET     24'h00_0000
`define PD_ALL          4'hF
`define TP_OFF          2'h3
`define PHASE_OFF       3'h7
`define PUMP_MAX        3'h7
`define MAIN_MIN        13'h0003
`define GAIN_STEP_DB    5'h03

`define SYS_CLK_KHZ     20000
`define MAX_SCLK_KHZ    20000
`define MIN_HALF_CYCLES ((`SYS_CLK_KHZ + 2 * `MAX_SCLK_KHZ - 1) / (2 * `MAX_SCLK_KHZ))

`define REG_WORD        4'h0
`define REG_STATUS      4'h4
`define REG_CONTROL     4'h8
`define ST_BUSY         0
`define ST_REJ          1
`define ST_DONE         2
`define ST_STAGE_LO     4
`define CTL_RESTART     0
`define CTL_CHECK       1
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

/* File: rtl/rf_latch_pkg.sv */
/*
  Types shared by both ends of the serial configuration link.
  Assumes rf_latch_regs.svh is on the include path.
*/
`include "rf_latch_regs.svh"
package rf_latch_pkg;
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_LOW  = 2'b01,
        PH_HIGH = 2'b10,
        PH_LOAD = 2'b11
    } tx_phase_t;

    typedef enum logic [2:0] {
        STG_PD    = 3'b000,
        STG_TX    = 3'b001,
        STG_CAL   = 3'b010,
        STG_PWRUP = 3'b011,
        STG_LO    = 3'b100,
        STG_RX    = 3'b101,
        STG_DONE  = 3'b110
    } init_stage_t;

    typedef struct packed {
        logic [2:0]  clkSync;
        logic [2:0]  dataSync;
        logic [2:0]  leSync;
        logic        clkLvl;
        logic        dataLvl;
        logic        leLvl;
        logic [23:0] shift;
        logic [4:0]  bitCnt;
        logic [23:0] ctrlLatch;
        logic [23:0] loLatch;
        logic [23:0] rxLatch;
        logic        stored;
    } dev_state_t;

    typedef struct packed {
        logic        awHeld;
        logic        wHeld;
        logic [3:0]  awAddr;
        logic [31:0] wData;
        logic [3:0]  wStrb;
        logic        bValid;
        logic [1:0]  bResp;
        logic        rValid;
        logic [31:0] rData;
        logic [1:0]  rResp;
        logic [23:0] word;
        logic        rejected;
        logic        checkEn;
        init_stage_t stage;
        tx_phase_t   phase;
        logic [23:0] shift;
        logic [4:0]  bitCnt;
        logic [8:0]  div;
        logic        sclk;
        logic        serial_data_in;
        logic        le;
    } host_state_t;
endpackage

/* File: rtl/rf_serial_if.sv */
/*
  Three-wire write link between host controller and latch device.
  Assumes the host drives all three lines; nothing flows back.
*/
`timescale 1ns/100ps
interface rf_serial_if;
    logic serialClk;
    logic serialDataIn;
    logic loadEnableStrobe;
    modport host   (output serialClk, output serialDataIn, output loadEnableStrobe);
    modport device (input serialClk, input serialDataIn, input loadEnableStrobe);
endinterface

/* File: rtl/rf_latch_device.sv */
/*
  Device end: samples the three-wire link on sys_clk, shifts words in and
  stores them into the control, LO divider and receive filter latches, and
  presents the decoded fields.
  Assumes link lines come from another clock domain and a link half period
  of at least two sys_clk cycles.
*/
// Notes on behaviour
// R1: prescaler select bits pick the prescaler value
// R2: pump gain 0 uses control current, 1 max
// R3: feedback select 0 oscillator, 1 mux signal
// R4: main counter holds 3 to 8191 only; host rejects lower values, but the device latch resets to 0 and only flags it
// R5: swallow counter takes 0 to 31 binary
// R6: address 11 stores receive filter latch
// R7: boost bit 1 on, 0 off
// R8: host pairs boost with calibration timeout count; host checks only the calibration word address
// R9: cutoff select field picks receive bandwidth
// R10: gain code sets 3 to 24 dB
// R11: host first powers down, output and phase off
// R12: host writes latches in fixed init order
// R13: host uses only clock, data, load lines
// R14: host keeps serial clock at most 20 MHz
// R15: address 10 stores LO divider latch
// R16: power-down bit 1 off, 0 normal
// R17: shift on clock edges, copy on load
`timescale 1ns/100ps
`include "rf_latch_regs.svh"
module rf_latch_device (
    input  wire logic           sys_clk,
    input  wire logic           sys_rst,
    rf_serial_if.device         link,
    output logic [1:0]          prescalerSelect,
    output logic [2:0]          pumpCurrent,
    output logic                pumpCurrentMaxSelect,
    output logic                feedbackFromMux,
    output logic [12:0]         mainCounterValue,
    output logic                mainCounterInvalid,
    output logic [4:0]          swallowCounterValue,
    output logic                settlingBoostEnable,
    output logic [1:0]          rxCutoffSelect,
    output logic [2:0]          rxGainCode,
    output logic [4:0]          rxGainDb,
    output logic [3:0]          sectionPowerDownBits,
    output logic                rxFilterPowerDown,
    output logic                synthPowerDown,
    output logic                oscPowerDown,
    output logic                txPowerDown,
    output logic                wordStored
);
    import rf_latch_pkg::*;

    dev_state_t s_r;
    dev_state_t s_nxt;
    logic       clkRise;
    logic       leRise;
    logic [1:0] addr;

    always_comb begin
        s_nxt = s_r;
        // Bit 0 of each sync chain feeds only bit 1
        s_nxt.clkSync  = {s_r.clkSync[1:0], link.serialClk};
        s_nxt.dataSync = {s_r.dataSync[1:0], link.serialDataIn};
        s_nxt.leSync   = {s_r.leSync[1:0], link.loadEnableStrobe};
        // A level is accepted only once stages two and three agree
        if (s_r.clkSync[1] == s_r.clkSync[2]) begin
            s_nxt.clkLvl = s_r.clkSync[2];
        end
        if (s_r.dataSync[1] == s_r.dataSync[2]) begin
            s_nxt.dataLvl = s_r.dataSync[2];
        end
        if (s_r.leSync[1] == s_r.leSync[2]) begin
            s_nxt.leLvl = s_r.leSync[2];
        end
        clkRise = s_nxt.clkLvl & ~s_r.clkLvl;
        leRise  = s_nxt.leLvl & ~s_r.leLvl;
        addr    = s_r.shift[1:0];
        s_nxt.stored = 1'b0;
        if (clkRise) begin
            // MSB first; data is stable across the clock edge
            s_nxt.shift = {s_r.shift[22:0], s_r.dataLvl};  // [R17]
            if (s_r.bitCnt != 5'(`WORD_BITS)) begin
                s_nxt.bitCnt = s_r.bitCnt + 5'h01;
            end
        end
        if (leRise) begin
            s_nxt.bitCnt = 5'h00;
            // A short word is dropped rather than half-written into a latch
            if (s_r.bitCnt == 5'(`WORD_BITS)) begin
                s_nxt.stored = 1'b1;
                unique case (addr)
                    `ADDR_CTRL:  s_nxt.ctrlLatch = s_r.shift;  // [R17]
                    `ADDR_LO:    s_nxt.loLatch   = s_r.shift;  // [R15]
                    `ADDR_RX:    s_nxt.rxLatch   = s_r.shift;  // [R6]
                    `ADDR_TXCAL: s_nxt.stored    = 1'b0;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_r           <= '0;
            s_r.ctrlLatch <= `CTRL_RESET;
            s_r.loLatch   <= `LATCH_RESET;
            s_r.rxLatch   <= `LATCH_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // LO divider latch fields
    assign prescalerSelect      = s_r.loLatch[`LO_PRESC_HI:`LO_PRESC_LO];  // [R1]
    assign pumpCurrentMaxSelect = s_r.loLatch[`LO_PUMP_BIT];
    // Gain override wins over the control latch current setting
    assign pumpCurrent = pumpCurrentMaxSelect ? `PUMP_MAX
                       : s_r.ctrlLatch[`CTRL_CPI_HI:`CTRL_CPI_LO];  // [R2]
    assign feedbackFromMux      = s_r.loLatch[`LO_FBSEL_BIT];  // [R3]
    assign mainCounterValue     = s_r.loLatch[`LO_MAIN_HI:`LO_MAIN_LO];
    // Values below the floor are stored as written but flagged
    assign mainCounterInvalid   = mainCounterValue < `MAIN_MIN;  // [R4]
    assign swallowCounterValue  = s_r.loLatch[`LO_SWAL_HI:`LO_SWAL_LO];  // [R5]

    // Receive filter latch fields
    assign settlingBoostEnable  = s_r.rxLatch[`RX_BOOST_BIT];  // [R7]
    assign rxCutoffSelect       = s_r.rxLatch[`RX_CUT_HI:`RX_CUT_LO];  // [R9]
    assign rxGainCode           = s_r.rxLatch[`RX_GAIN_HI:`RX_GAIN_LO];
    // Code 0 is 3 dB, each step adds 3 dB up to 24 dB
    assign rxGainDb = 5'(({2'b00, rxGainCode} + 5'h01) * `GAIN_STEP_DB);  // [R10]

    // Control latch power-down bits, PD4 down to PD1
    assign sectionPowerDownBits = s_r.ctrlLatch[`CTRL_PD_HI:`CTRL_PD_LO];  // [R16]
    assign rxFilterPowerDown    = sectionPowerDownBits[3];
    assign synthPowerDown       = sectionPowerDownBits[2];
    assign oscPowerDown         = sectionPowerDownBits[1];
    assign txPowerDown          = sectionPowerDownBits[0];
    assign wordStored           = s_r.stored;
endmodule

/* File: rtl/rf_latch_host.sv */
/*
  Host end: AXI4-Lite slave holding a word register, status and control; each
  accepted word is sent MSB first over the three-wire link, then loaded.
  Assumes one software master; serial clock is divided from sys_clk.
*/
`timescale 1ns/100ps
`include "rf_latch_regs.svh"
module rf_latch_host #(
    parameter logic [7:0] HALF_CYCLES = 8'h02
) (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic [3:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [3:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    rf_serial_if.host        link
);
    import rf_latch_pkg::*;

    localparam logic [7:0] MIN_HALF = 8'(`MIN_HALF_CYCLES);
    // Never faster than the link maximum, whatever the parameter says
    localparam logic [7:0] HALF = (HALF_CYCLES > MIN_HALF) ? HALF_CYCLES : MIN_HALF;

    host_state_t s_r;
    host_state_t s_nxt;
    logic        busy;
    logic        doWrite;
    logic        ok;
    logic        mainOk;
    logic [23:0] w;
    logic [31:0] status;

    assign busy    = s_r.phase != PH_IDLE;
    assign awready = ~s_r.awHeld;
    assign wready  = ~s_r.wHeld;
    assign arready = ~s_r.rValid;
    assign bvalid  = s_r.bValid;
    assign bresp   = s_r.bResp;
    assign rvalid  = s_r.rValid;
    assign rdata   = s_r.rData;
    assign rresp   = s_r.rResp;
    assign link.serialClk        = s_r.sclk;  // [R13]
    assign link.serialDataIn     = s_r.serial_data_in;
    assign link.loadEnableStrobe = s_r.le;

    assign status = {25'h000_0000, s_r.stage, 1'b0, s_r.stage == STG_DONE,
                     s_r.rejected, busy};

    always_comb begin
        s_nxt = s_r;
        w = s_r.word;
        for (int i = 0; i < 3; i++) begin
            if (s_r.wStrb[i]) begin
                w[i*8 +: 8] = s_r.wData[i*8 +: 8];
            end
        end
        mainOk = w[`LO_MAIN_HI:`LO_MAIN_LO] >= `MAIN_MIN;
        ok = 1'b1;
        if (w[1:0] == `ADDR_LO && !mainOk) begin
            ok = 1'b0;  // [R4]
        end else if (s_r.checkEn) begin
            unique case (s_r.stage)
                STG_PD: ok = w[1:0] == `ADDR_CTRL
                             && w[`CTRL_PD_HI:`CTRL_PD_LO] == `PD_ALL
                             && w[`CTRL_TP_HI:`CTRL_TP_LO] == `TP_OFF;  // [R11]
                STG_TX:    ok = w[2:0] == `ADDR3_TX
                                && w[`TX_PHASE_HI:`TX_PHASE_LO] == `PHASE_OFF;  // [R11]
                STG_CAL:   ok = w[2:0] == `ADDR3_CAL;  // [R12] [R8]
                STG_PWRUP: ok = w[1:0] == `ADDR_CTRL;  // [R12]
                STG_LO:    ok = w[1:0] == `ADDR_LO;  // [R12]
                STG_RX:    ok = w[1:0] == `ADDR_RX;  // [R12]
                STG_DONE:  ok = 1'b1;
                default:   ok = 1'b0;
            endcase
        end

        if (awvalid && !s_r.awHeld) begin
            s_nxt.awHeld = 1'b1;
            s_nxt.awAddr = awaddr;
        end
        if (wvalid && !s_r.wHeld) begin
            s_nxt.wHeld = 1'b1;
            s_nxt.wData = wdata;
            s_nxt.wStrb = wstrb;
        end
        if (s_r.bValid && bready) begin
            s_nxt.bValid = 1'b0;
        end
        // A word write waits for the link to go idle, stalling the bus
        doWrite = s_r.awHeld && s_r.wHeld && !s_r.bValid
                  && !(s_r.awAddr == `REG_WORD && busy);
        if (doWrite) begin
            s_nxt.awHeld = 1'b0;
            s_nxt.wHeld  = 1'b0;
            s_nxt.bValid = 1'b1;
            s_nxt.bResp  = `RESP_OKAY;
            unique case (s_r.awAddr)
                `REG_WORD: begin
                    s_nxt.word = w;
                    if (ok) begin
                        s_nxt.phase  = PH_LOW;
                        s_nxt.shift  = w;
                        s_nxt.serial_data_in  = w[23];
                        s_nxt.bitCnt = 5'h00;
                        s_nxt.div    = 9'h000;
                        if (s_r.stage != STG_DONE) begin
                            s_nxt.stage = init_stage_t'(3'(s_r.stage) + 3'h1);
                        end
                    end
                end
                `REG_STATUS: begin
                    if (s_r.wStrb[0] && s_r.wData[`ST_REJ]) begin
                        s_nxt.rejected = 1'b0;
                    end
                end
                `REG_CONTROL: begin
                    if (s_r.wStrb[0]) begin
                        s_nxt.checkEn = s_r.wData[`CTL_CHECK];
                        if (s_r.wData[`CTL_RESTART]) begin
                            s_nxt.stage = STG_PD;
                        end
                    end
                end
                default: s_nxt.bResp = `RESP_SLVERR;
            endcase
            // Rejection set wins over a clear
            if (s_r.awAddr == `REG_WORD && !ok) begin
                s_nxt.rejected = 1'b1;
            end
        end

        if (s_r.rValid && rready) begin
            s_nxt.rValid = 1'b0;
        end
        if (arvalid && !s_r.rValid) begin
            s_nxt.rValid = 1'b1;
            s_nxt.rResp  = `RESP_OKAY;
            unique case (araddr)
                `REG_WORD:    s_nxt.rData = {8'h00, s_r.word};
                `REG_STATUS:  s_nxt.rData = status;
                `REG_CONTROL: s_nxt.rData = {30'h0000_0000, s_r.checkEn, 1'b0};
                default: begin
                    s_nxt.rData = 32'h0000_0000;
                    s_nxt.rResp = `RESP_SLVERR;
                end
            endcase
        end

        if (busy) begin
            s_nxt.div = s_r.div + 9'h001;
        end
        unique case (s_r.phase)
            PH_IDLE: ;
            PH_LOW: begin
                if (s_r.div == 9'(HALF - 8'h01)) begin
                    s_nxt.phase = PH_HIGH;
                    s_nxt.sclk  = 1'b1;  // [R14]
                    s_nxt.div   = 9'h000;
                end
            end
            PH_HIGH: begin
                if (s_r.div == 9'(HALF - 8'h01)) begin
                    s_nxt.sclk = 1'b0;
                    s_nxt.div  = 9'h000;
                    if (s_r.bitCnt == 5'(`WORD_BITS - 1)) begin
                        s_nxt.phase = PH_LOAD;
                    end else begin
                        s_nxt.phase  = PH_LOW;
                        s_nxt.bitCnt = s_r.bitCnt + 5'h01;
                        s_nxt.shift  = {s_r.shift[22:0], 1'b0};
                        s_nxt.serial_data_in  = s_r.shift[22];
                    end
                end
            end
            PH_LOAD: begin
                // Load pulse rises one half period after the last falling edge
                if (s_r.div == 9'(HALF - 8'h01)) begin
                    s_nxt.le = 1'b1;  // [R17]
                end
                if (s_r.div == 9'({HALF, 1'b0} - 9'h001)) begin
                    s_nxt.le    = 1'b0;
                    s_nxt.phase = PH_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_r         <= '0;
            s_r.checkEn <= 1'b1;
            s_r.stage   <= STG_PD;
            s_r.phase   <= PH_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

/* File: sim/rf_serial_link_sva.sv */
/*
  Timing checks on the three wires between host end and device end.
  Assumes the host runs with HALF_CYCLES of 2 and both ends share sys_clk.
*/
`timescale 1ns/100ps
module rf_serial_link_sva (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic serialClk,
    input wire logic serialDataIn,
    input wire logic loadEnableStrobe
);
    logic [5:0] bitCnt_r;
    logic       clkDly_r;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // Rising link edges since the last load; a short word would be dropped
    always_ff @(posedge sys_clk) begin
        clkDly_r <= serialClk;
        if (sys_rst || loadEnableStrobe) begin
            bitCnt_r <= 6'h00;
        end else if (serialClk && !clkDly_r) begin
            bitCnt_r <= bitCnt_r + 6'h01;
        end
    end

    a_reset_lines_idle: assert property ($past(sys_rst) |-> !serialClk && !loadEnableStrobe)
        else $error("link not idle after reset");
    a_data_moves_low: assert property ($changed(serialDataIn) |-> !serialClk)
        else $error("data changed while link clock high");
    a_clk_high_min: assert property ($rose(serialClk) |-> serialClk [*2])
        else $error("link clock high phase too short");
    a_clk_low_min: assert property ($fell(serialClk) |-> !serialClk [*2])
        else $error("link clock low phase too short");
    a_load_clk_quiet: assert property (loadEnableStrobe |-> !serialClk)
        else $error("link clock moved during load");
    a_load_whole_word: assert property ($rose(loadEnableStrobe) |-> bitCnt_r == 6'h18)
        else $error("load not preceded by exactly 24 bits");
    a_load_pulse_width: assert property ($rose(loadEnableStrobe) |->
        loadEnableStrobe [*2] ##1 !loadEnableStrobe)
        else $error("load pulse width wrong");
    a_load_follows_word: assert property ($fell(serialClk) && bitCnt_r == 6'h18 |->
        ##[1:6] $rose(loadEnableStrobe))
        else $error("no load after a full word");
endmodule

/* File: sim/rf_frontend_serial_latches_tb_top.sv */
/*
  Bench: AXI4-Lite host end joined to the latch device end over the link.
  Assumes HALF_CYCLES of 2, a 50 ns sys_clk and one bus access at a time.
*/
`timescale 1ns/100ps
`include "rf_latch_regs.svh"
module rf_frontend_serial_latches_tb_top;
    import rf_latch_pkg::*;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, prescalerSelect, rxCutoffSelect;
    logic [2:0]  pumpCurrent, rxGainCode;
    logic        pumpCurrentMaxSelect, feedbackFromMux, mainCounterInvalid, settlingBoostEnable;
    logic        rxFilterPowerDown, synthPowerDown, oscPowerDown, txPowerDown, wordStored;
    logic [12:0] mainCounterValue;
    logic [4:0]  swallowCounterValue, rxGainDb;
    logic [3:0]  sectionPowerDownBits;
    logic [31:0] rd;
    int          errorCnt = 0, checkCount = 0;
    int          storedCnt = 0;

    always #25 sys_clk = ~sys_clk;

    // Store pulses last one cycle, so they are counted rather than sampled
    always @(posedge sys_clk) if (wordStored) storedCnt <= storedCnt + 1;

    rf_serial_if serialLink ();
    rf_latch_host rf_latch_host_inst (.sys_clk, .sys_rst, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .link(serialLink.host));
    rf_latch_device rf_latch_device_inst (.sys_clk, .sys_rst, .link(serialLink.device),
        .prescalerSelect, .pumpCurrent, .pumpCurrentMaxSelect, .feedbackFromMux,
        .mainCounterValue, .mainCounterInvalid, .swallowCounterValue, .settlingBoostEnable,
        .rxCutoffSelect, .rxGainCode, .rxGainDb, .sectionPowerDownBits, .rxFilterPowerDown,
        .synthPowerDown, .oscPowerDown, .txPowerDown, .wordStored);
    rf_serial_link_sva rf_serial_link_sva_inst (.sys_clk, .sys_rst,
        .serialClk(serialLink.serialClk), .serialDataIn(serialLink.serialDataIn),
        .loadEnableStrobe(serialLink.loadEnableStrobe));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checkCount++;
        if (got !== exp) begin
            $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
            errorCnt++;
        end
    endtask

    task automatic axiWr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        logic awOk, wOk, bOk;
        logic [1:0] resp;
        int n;
        bOk = 1'b0;
        n = 0;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!bOk && n < 5000) begin
            @(negedge sys_clk);
            awOk = awvalid && awready;
            wOk = wvalid && wready;
            bOk = bvalid;
            resp = bresp;
            n++;
            @(posedge sys_clk);
            if (awOk) awvalid <= 1'b0;
            if (wOk) wvalid <= 1'b0;
            if (bOk) bready <= 1'b0;
        end
        chk({31'h0, bOk}, 32'h0000_0001, "write answered");
        chk({30'h0, resp}, {30'h0, er}, "write response");
    endtask

    task automatic axiRd(input logic [3:0] a, output logic [31:0] d, input logic [1:0] er);
        logic arOk, rOk;
        logic [1:0] resp;
        int n;
        rOk = 1'b0;
        n = 0;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!rOk && n < 5000) begin
            @(negedge sys_clk);
            arOk = arvalid && arready;
            rOk = rvalid;
            d = rdata;
            resp = rresp;
            n++;
            @(posedge sys_clk);
            if (arOk) arvalid <= 1'b0;
            if (rOk) rready <= 1'b0;
        end
        chk({31'h0, rOk}, 32'h0000_0001, "read answered");
        chk({30'h0, resp}, {30'h0, er}, "read response");
    endtask

    // Sends one word, waits for the link to go idle and the latch to settle
    task automatic sendWord(input logic [23:0] w, input logic expRej);
        int i;
        axiWr(`REG_WORD, {8'h00, w}, `RESP_OKAY);
        rd = 32'h0000_0001;
        for (i = 0; i < 400 && rd[0] !== 1'b0; i++) axiRd(`REG_STATUS, rd, `RESP_OKAY);
        chk({31'h0, rd[0]}, 32'h0000_0000, "link went idle");
        repeat (8) @(posedge sys_clk);
        chk({31'h0, rd[1]}, {31'h0, expRej}, "word rejected flag");
        if (rd[1] === 1'b1) axiWr(`REG_STATUS, 32'h0000_0002, `RESP_OKAY);
    endtask

    function automatic logic [23:0] loWord(input logic [1:0] p, input logic g, input logic m,
                                           input logic [12:0] b, input logic [4:0] s);
        return {p, g, m, b, s, 2'b10};
    endfunction

    task automatic tResetValues();
        chk({28'h0, sectionPowerDownBits}, 32'h0000_000F, "power down bits at reset");
        chk({29'h0, pumpCurrent}, 32'h0000_0000, "pump current at reset");
        chk({31'h0, mainCounterInvalid}, 32'h0000_0001, "main counter flag at reset");
        chk({27'h0, rxGainDb}, 32'h0000_0003, "gain at reset");
        axiRd(`REG_STATUS, rd, `RESP_OKAY);
        chk(rd, 32'h0000_0000, "status at reset");
        axiRd(`REG_CONTROL, rd, `RESP_OKAY);
        chk(rd, 32'h0000_0002, "control at reset");
        axiWr(4'hC, 32'h0000_00FF, `RESP_SLVERR);
        axiRd(4'hC, rd, `RESP_SLVERR);
        chk(rd, 32'h0000_0000, "unmapped read data");
    endtask

    task automatic tInitOrder();
        sendWord(24'h00_00DF, 1'b1);
        chk({27'h0, rxGainDb}, 32'h0000_0003, "early filter word kept out");
        sendWord(24'hFC_0000, 1'b0);
        chk({28'h0, rxFilterPowerDown, synthPowerDown, oscPowerDown, txPowerDown},
            32'h0000_000F, "all sections down");
        sendWord(24'hE0_0001, 1'b0);
        sendWord(24'h00_0005, 1'b0);
        sendWord(24'h02_8000, 1'b0);
        chk({28'h0, sectionPowerDownBits}, 32'h0000_0000, "sections powered up");
        sendWord(loWord(2'b10, 1'b0, 1'b1, 13'h1FFF, 5'h1F), 1'b0);
        chk({30'h0, prescalerSelect}, 32'h0000_0002, "prescaler");
        chk({29'h0, pumpCurrent}, 32'h0000_0005, "pump from control latch");
        chk({31'h0, feedbackFromMux}, 32'h0000_0001, "feedback from mux");
        chk({19'h0, mainCounterValue}, 32'h0000_1FFF, "main counter top");
        chk({27'h0, swallowCounterValue}, 32'h0000_001F, "swallow top");
        chk({31'h0, mainCounterInvalid}, 32'h0000_0000, "main counter valid");
        sendWord(24'h00_00DF, 1'b0);
        chk({31'h0, settlingBoostEnable}, 32'h0000_0001, "boost on");
        chk({27'h0, rxGainDb}, 32'h0000_0018, "gain 24 dB");
        chk(32'(storedCnt), 32'h0000_0004, "words stored");
        axiRd(`REG_STATUS, rd, `RESP_OKAY);
        chk({29'h0, rd[6:4]}, {29'h0, STG_DONE}, "init stage done");
    endtask

    task automatic tSweep();
        int i;
        for (i = 0; i < 8; i++) begin
            sendWord({16'h0000, i[0], i[1:0], i[2:0], 2'b11}, 1'b0);
            chk({31'h0, settlingBoostEnable}, {31'h0, i[0]}, "boost bit");
            chk({30'h0, rxCutoffSelect}, {30'h0, i[1:0]}, "cutoff select");
            chk({27'h0, rxGainDb}, 32'(3 * (i + 1)), "gain step");
            chk({29'h0, rxGainCode}, {29'h0, i[2:0]}, "gain code");
        end
        for (i = 0; i < 4; i++) begin
            sendWord(loWord(i[1:0], i[0], i[1], 13'(3 + i), 5'(i)), 1'b0);
            chk({30'h0, prescalerSelect}, {30'h0, i[1:0]}, "prescaler code");
            chk({29'h0, pumpCurrent}, i[0] ? 32'h0000_0007 : 32'h0000_0005, "pump");
            chk({31'h0, pumpCurrentMaxSelect}, {31'h0, i[0]}, "pump max select");
            chk({31'h0, feedbackFromMux}, {31'h0, i[1]}, "feedback select");
            chk({19'h0, mainCounterValue}, 32'(3 + i), "main counter low end");
            chk({27'h0, swallowCounterValue}, 32'(i), "swallow low end");
        end
        sendWord(loWord(2'b00, 1'b0, 1'b0, 13'h0002, 5'h00), 1'b1);
        chk({19'h0, mainCounterValue}, 32'h0000_0006, "main below 3 not sent");
        // Restart with order checking off: a filter word is then taken at stage 0
        axiWr(`REG_CONTROL, 32'h0000_0001, `RESP_OKAY);
        axiRd(`REG_CONTROL, rd, `RESP_OKAY);
        chk(rd, 32'h0000_0000, "checking off");
        axiRd(`REG_STATUS, rd, `RESP_OKAY);
        chk(rd, 32'h0000_0000, "restart to first stage");
        sendWord(24'h00_0003, 1'b0);
        chk({27'h0, rxGainDb}, 32'h0000_0003, "unchecked filter word");
        chk(32'(storedCnt), 32'h0000_0011, "words stored in sweep");
    endtask

    task automatic results();
        $display("checks %0d errors %0d", checkCount, errorCnt);
        if (errorCnt == 0 && checkCount > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge sys_clk);
        errorCnt++;
        $display("ERROR %0t watchdog expired", $time);
        results();
    end

    initial begin
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        tResetValues();
        tInitOrder();
        tSweep();
        results();
    end
endmodule
